// ---- hw/fpe_ctrl.sv ----
// flash program/erase controller: unlock key, enables, core stall
// Contract
// - programming can only clear bits; erased bytes read 0xFF.
// - program and erase are timed internally, no polling needed.
// - core is stalled for the whole program or erase.
// - unlock needs 0xA5 then 0xF1 written to the key register.
// - a wrong or out-of-order key blocks flash until system reset.
// - a flash store before full unlock blocks flash until reset.
// - each program or erase relocks the key in the cycle it starts.
// - with write enable set, data-move stores go to flash, not RAM.
// - write enable changes only by firmware write, never by hardware.
// - erase clears a whole 512-byte page to 0xFF.
// - unlock, erase enable, write enable, then store erases that page.
// - program needs write enable; erase needs both enables.
// - single-byte mode: each flash store starts one timed program.
// - flash store with supply monitor off requests flash error reset.
module fpe_ctrl #(
  parameter int AW = 16,
  parameter int PROG_CNT = fpe_pkg::PROG_CYCLES,
  parameter int ERASE_CNT = fpe_pkg::ERASE_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic key_wr,
  input wire logic [7:0] key_wdata,
  input wire logic psc_wr,
  input wire logic [1:0] psc_wdata,
  input wire logic flash_read_timing_select,
  input wire logic supply_monitor_en,
  input wire logic xdm_wr,
  input wire logic [AW-1:0] xdm_addr,
  input wire logic [7:0] xdm_wdata,
  input wire logic [7:0] flash_rdata,
  output logic xram_we,
  output logic [AW-1:0] xram_addr,
  output logic [7:0] xram_wdata,
  output logic flash_we,
  output logic flash_page_erase,
  output logic [AW-1:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic core_stall,
  output logic [1:0] program_store_control,
  output logic [1:0] key_state,
  output logic flash_error_reset_req,
  output logic flash_read_wait
);
  fpe_pkg::fpe_key_e key_q, key_d;
  logic [1:0] psc_q, psc_d;
  logic err_q, err_d;
  logic to_flash, op_go;
  fpe_array_if #(.AW(AW)) arr ();

  fpe_engine #(.AW(AW), .PROG_CNT(PROG_CNT), .ERASE_CNT(ERASE_CNT)) u_eng (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .ctl(arr.eng),
    .flash_rdata(flash_rdata),
    .flash_we(flash_we),
    .flash_page_erase(flash_page_erase),
    .flash_addr(flash_addr),
    .flash_wdata(flash_wdata)
  );

  assign to_flash = xdm_wr && psc_q[fpe_pkg::PSC_WE_BIT] && !arr.busy;
  assign op_go = to_flash && key_q == fpe_pkg::FPE_OPEN && supply_monitor_en;

  always_comb begin
    key_d = key_q;
    psc_d = psc_q;
    err_d = 1'b0;
    // firmware only; no hardware path touches the enables
    if (psc_wr) psc_d = psc_wdata;
    unique case (key_q)
      fpe_pkg::FPE_IDLE: begin
        if (key_wr) key_d = (key_wdata == fpe_pkg::KEY_FIRST) ? fpe_pkg::FPE_FIRST
                                                              : fpe_pkg::FPE_LOCKOUT;
        else if (to_flash) key_d = fpe_pkg::FPE_LOCKOUT;
      end
      fpe_pkg::FPE_FIRST: begin
        if (key_wr) key_d = (key_wdata == fpe_pkg::KEY_SECOND) ? fpe_pkg::FPE_OPEN
                                                               : fpe_pkg::FPE_LOCKOUT;
        else if (to_flash) key_d = fpe_pkg::FPE_LOCKOUT;
      end
      fpe_pkg::FPE_OPEN: begin
        // a further key write while open is out of sequence
        if (key_wr) key_d = fpe_pkg::FPE_LOCKOUT;
        else if (op_go) key_d = fpe_pkg::FPE_IDLE;
      end
      fpe_pkg::FPE_LOCKOUT: key_d = fpe_pkg::FPE_LOCKOUT;
    endcase
    if (to_flash && !supply_monitor_en) err_d = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      key_q <= fpe_pkg::FPE_IDLE;
      psc_q <= fpe_pkg::PSC_RESET;
      err_q <= 1'b0;
      xram_we <= 1'b0;
      xram_addr <= '0;
      xram_wdata <= '0;
    end else if (clk_en) begin
      key_q <= key_d;
      psc_q <= psc_d;
      err_q <= err_d;
      xram_we <= xdm_wr && !psc_q[fpe_pkg::PSC_WE_BIT];
      xram_addr <= xdm_addr;
      xram_wdata <= xdm_wdata;
    end
  end

  assign arr.start = op_go;
  assign arr.erase = psc_q[fpe_pkg::PSC_EE_BIT];
  assign arr.addr = xdm_addr;
  assign arr.data = xdm_wdata;
  // stall from the triggering store until the engine completes
  assign core_stall = op_go || arr.busy;
  assign program_store_control = psc_q;
  assign key_state = key_q;
  assign flash_error_reset_req = err_q;
  assign flash_read_wait = flash_read_timing_select;

  a_lockout_sticky: assert property (@(posedge core_clk) disable iff (srst)
    key_q == fpe_pkg::FPE_LOCKOUT |=> key_q == fpe_pkg::FPE_LOCKOUT)
    else $error("lockout left without reset");
  a_bad_key_locks: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && key_wr && key_q == fpe_pkg::FPE_IDLE && key_wdata != fpe_pkg::KEY_FIRST
    |=> key_q == fpe_pkg::FPE_LOCKOUT)
    else $error("wrong first key did not lock out");
  a_early_store: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && !key_wr && to_flash && key_q == fpe_pkg::FPE_IDLE
    |=> key_q == fpe_pkg::FPE_LOCKOUT)
    else $error("store before unlock did not lock out");
  a_relock: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && op_go && !key_wr |=> key_q == fpe_pkg::FPE_IDLE)
    else $error("key not relocked after operation");
  a_stall_held: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && op_go |=> core_stall [*4])
    else $error("core not stalled during operation");
  a_we_kept: assert property (@(posedge core_clk) disable iff (srst)
    !psc_wr && clk_en |=> $stable(psc_q))
    else $error("write enable changed without firmware");
  a_ram_route: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && xdm_wr && psc_q[fpe_pkg::PSC_WE_BIT] |=> !xram_we)
    else $error("flash-directed store reached RAM");
  a_monitor_err: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && to_flash && !supply_monitor_en |=> flash_error_reset_req && !arr.busy)
    else $error("monitor-off store not flagged");
  a_erase_needs: assert property (@(posedge core_clk) disable iff (srst)
    arr.start |-> psc_q[fpe_pkg::PSC_WE_BIT])
    else $error("operation without write enable");

  // unlock is a two-step walk: each step taken on an enabled edge
  sequence s_first_code;
    clk_en && key_wr && key_wdata == fpe_pkg::KEY_FIRST && key_q == fpe_pkg::FPE_IDLE;
  endsequence
  sequence s_second_code;
    clk_en && key_wr && key_wdata == fpe_pkg::KEY_SECOND && key_q == fpe_pkg::FPE_FIRST;
  endsequence
  a_first_code: assert property (@(posedge core_clk) disable iff (srst)
    s_first_code |=> key_q == fpe_pkg::FPE_FIRST)
    else $error("first key not taken");
  a_unlock_order: assert property (@(posedge core_clk) disable iff (srst)
    s_second_code |=> key_q == fpe_pkg::FPE_OPEN)
    else $error("correct key pair did not unlock");
  a_busy_stalls: assert property (@(posedge core_clk) disable iff (srst)
    arr.busy |-> core_stall)
    else $error("core ran during engine activity");
  // clock enable low must hold every piece of key and enable state
  a_freeze_state: assert property (@(posedge core_clk) disable iff (srst)
    !clk_en |=> $stable(key_q) && $stable(psc_q))
    else $error("state moved while clock enable low");
endmodule

// ---- hw/fpe_pkg.sv ----
// shared constants and types for the flash program/erase controller
package fpe_pkg;
  localparam logic [7:0] KEY_FIRST = 8'hA5;
  localparam logic [7:0] KEY_SECOND = 8'hF1;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int PAGE_BYTES = 512;
  localparam int PSC_WE_BIT = 0;
  localparam int PSC_EE_BIT = 1;
  localparam logic [1:0] PSC_RESET = 2'h0;
  localparam int CLK_MHZ = 100;
  localparam int PROG_TIME_NS = 40000;
  localparam int ERASE_TIME_NS = 4000000;
  localparam int PROG_CYCLES = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int ERASE_CYCLES = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {
    FPE_IDLE = 2'b00,
    FPE_FIRST = 2'b01,
    FPE_OPEN = 2'b10,
    FPE_LOCKOUT = 2'b11
  } fpe_key_e;
endpackage

// ---- hw/fpe_array_if.sv ----
// connection between sequencer and array timing engine
interface fpe_array_if #(parameter int AW = 16);
  logic start;
  logic erase;
  logic [AW-1:0] addr;
  logic [7:0] data;
  logic busy;
  logic done;
  modport seq (output start, output erase, output addr, output data, input busy, input done);
  modport eng (input start, input erase, input addr, input data, output busy, output done);
endinterface

// ---- hw/fpe_engine.sv ----
// timed program/erase engine driving the flash array
module fpe_engine #(
  parameter int AW = 16,
  parameter int PROG_CNT = fpe_pkg::PROG_CYCLES,
  parameter int ERASE_CNT = fpe_pkg::ERASE_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  fpe_array_if.eng ctl,
  input wire logic [7:0] flash_rdata,
  output logic flash_we,
  output logic flash_page_erase,
  output logic [AW-1:0] flash_addr,
  output logic [7:0] flash_wdata
);
  localparam int CW = $clog2(ERASE_CNT + 1);
  logic [CW-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d, done_q, done_d, er_q, er_d, we_d, pe_d;
  logic [AW-1:0] a_q, a_d;
  logic [7:0] w_q, w_d;

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    er_d = er_q;
    a_d = a_q;
    w_d = w_q;
    we_d = 1'b0;
    pe_d = 1'b0;
    if (!busy_q && ctl.start) begin
      busy_d = 1'b1;
      er_d = ctl.erase;
      a_d = ctl.addr;
      // program only clears bits: AND with current contents
      w_d = ctl.data & flash_rdata;
      cnt_d = ctl.erase ? CW'(ERASE_CNT - 1) : CW'(PROG_CNT - 1);
    end else if (busy_q) begin
      if (cnt_q == '0) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        we_d = !er_q;
        pe_d = er_q;
      end else begin
        cnt_d = cnt_q - CW'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      er_q <= 1'b0;
      a_q <= '0;
      w_q <= '0;
      flash_we <= 1'b0;
      flash_page_erase <= 1'b0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
      er_q <= er_d;
      a_q <= a_d;
      w_q <= w_d;
      flash_we <= we_d;
      flash_page_erase <= pe_d;
    end
  end

  // erase targets the page base so the array clears all of it
  assign flash_addr = er_q ? {a_q[AW-1:$clog2(fpe_pkg::PAGE_BYTES)],
                              {$clog2(fpe_pkg::PAGE_BYTES){1'b0}}} : a_q;
  assign flash_wdata = w_q;
  assign ctl.busy = busy_q;
  assign ctl.done = done_q;

  a_busy_bounded: assert property (@(posedge core_clk) disable iff (srst)
    $rose(busy_q) && !er_q && clk_en |-> ##[1:1000] !busy_q || !clk_en)
    else $error("program did not finish in time");
  a_erase_page: assert property (@(posedge core_clk) disable iff (srst)
    flash_page_erase |-> flash_addr[$clog2(fpe_pkg::PAGE_BYTES)-1:0] == '0)
    else $error("erase not aligned to page base");
endmodule

// ---- verif/fpe_core_model.sv ----
// core model issuing firmware stores to the flash controller
module fpe_core_model #(parameter int AW = 16) (
  input wire logic core_clk,
  input wire logic core_stall,
  output logic key_wr,
  output logic [7:0] key_wdata,
  output logic psc_wr,
  output logic [1:0] psc_wdata,
  output logic xdm_wr,
  output logic [AW-1:0] xdm_addr,
  output logic [7:0] xdm_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {key_wr, psc_wr, xdm_wr} = 3'h0;
    {key_wdata, psc_wdata, xdm_wdata} = 18'h0;
    xdm_addr = '0;
  end
  // k: 0 key, 1 control, 2 store; idle data is inverted so nothing stale passes
  task automatic op(input int k, input logic [AW-1:0] a, input logic [7:0] d);
    @(negedge core_clk);
    while (core_stall === 1'b1) @(negedge core_clk);
    key_wr = (k == 0);
    psc_wr = (k == 1);
    xdm_wr = (k == 2);
    key_wdata = d;
    psc_wdata = d[1:0];
    xdm_addr = a;
    xdm_wdata = d;
    @(negedge core_clk);
    {key_wr, psc_wr, xdm_wr} = 3'h0;
    {key_wdata, psc_wdata, xdm_wdata} = ~{d, d[1:0], d};
    xdm_addr = ~a;
  endtask
endmodule

// ---- verif/flash_program_erase_control_tb_top.sv ----
// self-checking bench for the flash program/erase controller
module flash_program_erase_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PC = 5;
  localparam int EC = 20;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic flash_read_timing_select = 1'b1;
  logic supply_monitor_en = 1'b1;
  logic key_wr, psc_wr, xdm_wr, xram_we, flash_we, flash_page_erase, core_stall;
  logic flash_error_reset_req, flash_read_wait;
  logic [7:0] key_wdata, xdm_wdata, flash_rdata, xram_wdata, flash_wdata;
  logic [15:0] xdm_addr, xram_addr, flash_addr;
  logic [1:0] psc_wdata, program_store_control, key_state;
  logic [7:0] mem [0:1023];
  int bad_count = 0;
  int num_checks = 0;
  assign flash_rdata = mem[xdm_addr[9:0]];
  fpe_ctrl #(.AW(16), .PROG_CNT(PC), .ERASE_CNT(EC)) i_dut (.core_clk, .srst, .clk_en,
    .key_wr, .key_wdata, .psc_wr, .psc_wdata, .flash_read_timing_select, .supply_monitor_en,
    .xdm_wr, .xdm_addr, .xdm_wdata, .flash_rdata, .xram_we, .xram_addr, .xram_wdata,
    .flash_we, .flash_page_erase, .flash_addr, .flash_wdata, .core_stall,
    .program_store_control, .key_state, .flash_error_reset_req, .flash_read_wait);
  fpe_core_model #(.AW(16)) i_core (.core_clk, .core_stall, .key_wr, .key_wdata, .psc_wr,
    .psc_wdata, .xdm_wr, .xdm_addr, .xdm_wdata);
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 8'h3C;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (flash_we === 1'b1) mem[flash_addr[9:0]] <= flash_wdata;
    if (flash_page_erase === 1'b1)
      for (int i = 0; i < 512; i++) mem[{flash_addr[9], i[8:0]}] <= 8'hFF;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic unlock();
    i_core.op(0, 0, fpe_pkg::KEY_FIRST);
    i_core.op(0, 0, fpe_pkg::KEY_SECOND);
  endtask
  // bounded wait for the commit pulse; count must fit the programmed length
  task automatic commit(input int lim);
    int n;
    n = 0;
    chk("stall", 16'h1, core_stall);
    while (flash_we !== 1'b1 && flash_page_erase !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    chk("op_time", 16'h1, n >= lim - 1 && n <= lim + 2);
    @(negedge core_clk);
    chk("stall_end", 16'h0, core_stall);
  endtask
  task automatic rst();
    @(negedge core_clk);
    srst = 1'b1;
    repeat (6) @(negedge core_clk);
    srst = 1'b0;
    chk("psc_rst", fpe_pkg::PSC_RESET, program_store_control);
    chk("key_rst", 16'h0, key_state);
  endtask
  task automatic t_prog();
    unlock();
    i_core.op(1, 0, 8'h01);
    i_core.op(2, 16'h0105, 8'h5A);
    commit(PC);
    chk("prog", 16'h18, mem[10'h105]);
    chk("relock", 16'h0, key_state);
    chk("we_kept", 16'h1, program_store_control);
    $display("t_prog done");
  endtask
  task automatic t_erase();
    unlock();
    i_core.op(1, 0, 8'h02);
    i_core.op(1, 0, 8'h03);
    i_core.op(2, 16'h0210, 8'h00);
    commit(EC);
    chk("pg_lo", 16'hFF, mem[10'h200]);
    chk("pg_hi", 16'hFF, mem[10'h3FF]);
    chk("pg_out", 16'h18, mem[10'h105]);
    i_core.op(1, 0, 8'h02);
    i_core.op(1, 0, 8'h00);
    $display("t_erase done");
  endtask
  task automatic t_xram();
    unlock();
    i_core.op(2, 16'h0123, 8'hC6);
    chk("xram", 16'h1, xram_we & ~core_stall);
    chk("xaddr", 16'h0123, xram_addr);
    chk("xdata", 16'hC6, xram_wdata);
    chk("rdwait", 16'h1, flash_read_wait);
    flash_read_timing_select = 1'b0;
    @(negedge core_clk);
    chk("rdwait_lo", 16'h0, flash_read_wait);
    flash_read_timing_select = 1'b1;
    $display("t_xram done");
  endtask
  // wrong order, then a correct pair and a store: nothing may reach the array
  task automatic t_order();
    i_core.op(0, 0, fpe_pkg::KEY_SECOND);
    chk("lock_ord", 16'h3, key_state);
    unlock();
    i_core.op(1, 0, 8'h01);
    i_core.op(2, 16'h0106, 8'h00);
    chk("no_stall", 16'h0, core_stall);
    repeat (PC + 4) @(negedge core_clk);
    chk("no_prog", 16'h3C, mem[10'h106]);
    rst();
    i_core.op(1, 0, 8'h01);
    i_core.op(2, 16'h0107, 8'h00);
    chk("lock_early", 16'h3, key_state);
    $display("t_order done");
  endtask
  task automatic t_mon();
    logic seen;
    seen = 1'b0;
    rst();
    // a key write with the clock enable low must leave the key idle
    clk_en = 1'b0;
    i_core.op(0, 0, fpe_pkg::KEY_FIRST);
    chk("freeze", 16'h0, key_state);
    clk_en = 1'b1;
    supply_monitor_en = 1'b0;
    unlock();
    i_core.op(1, 0, 8'h01);
    i_core.op(2, 16'h0108, 8'h00);
    repeat (PC + 4) begin
      seen |= (flash_error_reset_req === 1'b1);
      @(negedge core_clk);
    end
    chk("err_req", 16'h1, seen);
    chk("no_prog2", 16'h3C, mem[10'h108]);
    $display("t_mon done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    rst();
    t_prog();
    t_erase();
    t_xram();
    t_order();
    t_mon();
    results();
  end
  // runs use well under a thousand cycles
  initial begin
    #100us;
    bad_count++;
    results();
  end
endmodule
